// ### verilog/fetch_pkg.sv
// Constants and carriers for the instruction fetch bus master.
// Assumes one clock shared by the core and the local bus.
// Function
// - Cacheable output low for non-cacheable, high for cacheable; held until after ack.
// - Non-cacheable line is four words if size bit 0, eight if 1.
// - Non-cacheable lines stay in fill buffer only, served until reused.
// - Cacheable fetches use eight-word lines, served from buffer while arriving.
// - Complete cacheable line copied to cache unless fetch-without-allocate set.
// - Cacheable lines fetched by cache-block-touch always copied into the cache.
// - User attribute output reflects target memory; held until after ack.
// - After abort, request drops next cycle and stays low one cycle.
// - Two-bit priority 00 lowest to 11 highest, held until after ack.
// - Priority comes from configuration field resetting to binary 11.
// - Address ack lasts one cycle; next cycle request and ack low.
// - At most two outstanding; next request after request low one cycle.
// - Third request no earlier than two cycles after first's final ack.
// - 32-bit slave word duplicated, half picked by position; 64-bit gives both.
// - Read ack one-cycle pulse per transfer; data captured only then.
// - Transfers: 32-bit 4, 8, 8; 64-bit 2, 4, 4.
// - Line size code 01 for four words, 10 for eight words.
// - Address is a word address; slave aligns line by upper bits.
package fetch_pkg;
  localparam int ADDR_W = 30;
  localparam int WORD_W = 32;
  localparam int LINE_WORDS = 8;
  localparam logic [1:0] SIZE_FOUR = 2'b01;
  localparam logic [1:0] SIZE_EIGHT = 2'b10;
  localparam logic [1:0] IPP_RESET = 2'b11;
  // Transfers per line minus one
  localparam logic [2:0] LAST_FOUR_32 = 3'h3;
  localparam logic [2:0] LAST_EIGHT_32 = 3'h7;
  localparam logic [2:0] LAST_FOUR_64 = 3'h1;
  localparam logic [2:0] LAST_EIGHT_64 = 3'h3;
  localparam logic [1:0] MAX_OUT = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic cacheable;
    logic user_attr;
    logic touch;
  } fetch_cmd_t;

  typedef struct packed {
    logic noncache_line_size_sel;
    logic fetch_without_allocate;
    logic [1:0] ifetch_priority_field;
  } core_cfg_t;

  localparam core_cfg_t CFG_RESET = '{1'b0, 1'b0, IPP_RESET};

  typedef struct packed {
    logic vld;
    logic [ADDR_W-1:0] addr;
    logic eight;
    logic cacheable;
    logic touch;
    logic wide;
  } out_entry_t;

  typedef enum {ST_IDLE, ST_REQ} req_state_t;
endpackage

// ### verilog/instruction_fetch_bus_master.sv
// Instruction fetch bus master: request port, two-deep outstanding queue, fill buffer.
// Assumes the slave shares clk and keeps its side of the fetch protocol.
`timescale 1ns/100ps
`default_nettype none
module instruction_fetch_bus_master
  import fetch_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cfg_wr,
  input wire core_cfg_t cfg_in,
  input wire logic cmd_valid,
  input wire fetch_cmd_t cmd,
  output logic cmd_ready,
  input wire logic cmd_cancel,
  input wire logic [ADDR_W-1:0] lookup_addr,
  output logic lookup_hit,
  output logic [WORD_W-1:0] lookup_word,
  output logic cache_fill_valid,
  output logic [ADDR_W-4:0] cache_fill_addr,
  output logic [LINE_WORDS*WORD_W-1:0] cache_fill_line,
  output logic fetch_req,
  output logic [ADDR_W-1:0] fetch_word_addr,
  output logic [1:0] fetch_line_size,
  output logic fetch_cacheable,
  output logic fetch_user_attr,
  output logic [1:0] fetch_priority,
  output logic fetch_abort,
  input wire logic fetch_addr_ack,
  input wire logic slave_width_64,
  input wire logic fetch_rd_ack,
  input wire logic [2*WORD_W-1:0] fetch_rd_data,
  input wire logic [2:0] fetch_rd_word_pos
);

  core_cfg_t cfg_reg, cfg_next;
  req_state_t state_reg, state_next;
  logic req_reg, req_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [1:0] size_reg, size_next;
  logic cach_reg, cach_next;
  logic attr_reg, attr_next;
  logic touch_reg, touch_next;
  logic [1:0] prio_reg, prio_next;
  out_entry_t q0_reg, q0_next, q1_reg, q1_next;
  logic [2:0] beat_reg, beat_next;
  logic [1:0] out_cnt;
  logic push, pop, first_beat, beat_now;
  logic [2:0] last_idx, wr_idx;
  logic [ADDR_W-1:0] fb_addr_reg, fb_addr_next;
  logic fb_eight_reg, fb_eight_next;
  logic [WORD_W-1:0] fb_word_reg [LINE_WORDS];
  logic [WORD_W-1:0] fb_word_next [LINE_WORDS];
  logic [LINE_WORDS-1:0] fb_vld_reg, fb_vld_next;
  logic [LINE_WORDS*WORD_W-1:0] line_now;
  logic hit_reg, hit_next;
  logic [WORD_W-1:0] hword_reg, hword_next;
  logic fill_v_reg, fill_v_next;
  logic [ADDR_W-4:0] fill_a_reg, fill_a_next;
  logic [LINE_WORDS*WORD_W-1:0] fill_l_reg, fill_l_next;
  // Configuration shadow; priority field comes up at its highest level
  always_comb begin
    cfg_next = cfg_reg;
    if (cfg_wr) begin
      cfg_next = cfg_in;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_reg <= CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign out_cnt = {1'b0, q0_reg.vld} + {1'b0, q1_reg.vld};
  // issue spacing
  // Queue frees a slot only the cycle after the final beat, so a third request
  // can show at the earliest two cycles after it.
  assign cmd_ready = (state_reg == ST_IDLE) && (out_cnt < MAX_OUT);
  assign fetch_abort = req_reg & cmd_cancel;
  assign push = req_reg & fetch_addr_ack & ~fetch_abort;

  always_comb begin
    state_next = state_reg;
    req_next = req_reg;
    addr_next = addr_reg;
    size_next = size_reg;
    cach_next = cach_reg;
    attr_next = attr_reg;
    touch_next = touch_reg;
    prio_next = prio_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          state_next = ST_REQ;
          req_next = 1'b1;
          addr_next = cmd.addr;
          cach_next = cmd.cacheable;
          attr_next = cmd.user_attr;
          touch_next = cmd.touch;
          prio_next = cfg_reg.ifetch_priority_field;
          if (cmd.cacheable || cfg_reg.noncache_line_size_sel) begin
            size_next = SIZE_EIGHT;
          end else begin
            size_next = SIZE_FOUR;
          end
        end
      end
      ST_REQ: begin
        // request drops after ack or abort
        if (fetch_abort || fetch_addr_ack) begin
          state_next = ST_IDLE;
          req_next = 1'b0;
        end
      end
      default: begin
        state_next = ST_IDLE;
        req_next = 1'b0;
      end
    endcase
  end

  // attributes stay put from request until past ack
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      req_reg <= 1'b0;
      addr_reg <= '0;
      size_reg <= SIZE_FOUR;
      cach_reg <= 1'b0;
      attr_reg <= 1'b0;
      touch_reg <= 1'b0;
      prio_reg <= IPP_RESET;
    end else begin
      state_reg <= state_next;
      req_reg <= req_next;
      addr_reg <= addr_next;
      size_reg <= size_next;
      cach_reg <= cach_next;
      attr_reg <= attr_next;
      touch_reg <= touch_next;
      prio_reg <= prio_next;
    end
  end
  // word address out, low bits implied zero
  assign fetch_req = req_reg;
  assign fetch_word_addr = addr_reg;
  assign fetch_line_size = size_reg;
  assign fetch_cacheable = cach_reg;
  assign fetch_user_attr = attr_reg;
  assign fetch_priority = prio_reg;

  always_comb begin
    case ({q0_reg.eight, q0_reg.wide})
      2'b00: last_idx = LAST_FOUR_32;
      2'b10: last_idx = LAST_EIGHT_32;
      2'b01: last_idx = LAST_FOUR_64;
      2'b11: last_idx = LAST_EIGHT_64;
      default: last_idx = LAST_EIGHT_32;
    endcase
  end

  // data valid only on read ack
  assign beat_now = fetch_rd_ack & q0_reg.vld;
  assign first_beat = beat_now & (beat_reg == 3'h0);
  assign pop = beat_now & (beat_reg == last_idx);

  // width sampled at ack, in-order queue
  always_comb begin
    q0_next = q0_reg;
    q1_next = q1_reg;
    beat_next = beat_reg;
    if (pop) begin
      q0_next = q1_reg;
      q1_next = '0;
      beat_next = 3'h0;
    end else if (beat_now) begin
      beat_next = beat_reg + 3'h1;
    end
    if (push) begin
      if (!q0_next.vld) begin
        q0_next = '{1'b1, addr_reg, size_reg == SIZE_EIGHT, cach_reg, touch_reg, slave_width_64};
      end else begin
        q1_next = '{1'b1, addr_reg, size_reg == SIZE_EIGHT, cach_reg, touch_reg, slave_width_64};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q0_reg <= '0;
      q1_reg <= '0;
      beat_reg <= 3'h0;
    end else begin
      q0_reg <= q0_next;
      q1_reg <= q1_next;
      beat_reg <= beat_next;
    end
  end

  // slot from word position; four-word lines use the address half
  assign wr_idx = {q0_reg.eight ? fetch_rd_word_pos[2] : q0_reg.addr[2],
                   fetch_rd_word_pos[1:0]};

  // fill buffer retagged on a new line's first beat
  always_comb begin
    fb_addr_next = fb_addr_reg;
    fb_eight_next = fb_eight_reg;
    if (first_beat) begin
      fb_addr_next = q0_reg.addr;
      fb_eight_next = q0_reg.eight;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < LINE_WORDS; gi++) begin : g_slot
      logic wr;
      // wide slave fills a word pair per beat
      assign wr = beat_now & (q0_reg.wide ? (wr_idx[2:1] == 2'(gi / 2)) : (wr_idx == 3'(gi)));
      always_comb begin
        fb_word_next[gi] = fb_word_reg[gi];
        fb_vld_next[gi] = fb_vld_reg[gi] & ~first_beat;
        if (wr) begin
          // Even words ride the upper half of the read bus
          fb_word_next[gi] = (gi % 2 == 1) ? fetch_rd_data[WORD_W-1:0]
                                           : fetch_rd_data[2*WORD_W-1:WORD_W];
          fb_vld_next[gi] = 1'b1;
        end
      end
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          fb_word_reg[gi] <= '0;
          fb_vld_reg[gi] <= 1'b0;
        end else begin
          fb_word_reg[gi] <= fb_word_next[gi];
          fb_vld_reg[gi] <= fb_vld_next[gi];
        end
      end
      assign line_now[gi*WORD_W +: WORD_W] = fb_word_next[gi];
    end
  endgenerate

  // hits served per word, while the line is still arriving
  always_comb begin
    hit_next = fb_vld_reg[lookup_addr[2:0]];
    if (fb_eight_reg) begin
      hit_next = hit_next & (lookup_addr[ADDR_W-1:3] == fb_addr_reg[ADDR_W-1:3]);
    end else begin
      hit_next = hit_next & (lookup_addr[ADDR_W-1:2] == fb_addr_reg[ADDR_W-1:2]);
    end
    hword_next = fb_word_reg[lookup_addr[2:0]];
  end

  // full cacheable line goes to the cache unless fetch_without_allocate is set and touch is clear
  // Non-cacheable lines never reach this port.
  always_comb begin
    fill_v_next = pop & q0_reg.cacheable & (~cfg_reg.fetch_without_allocate | q0_reg.touch);
    fill_a_next = fill_a_reg;
    fill_l_next = fill_l_reg;
    if (fill_v_next) begin
      fill_a_next = q0_reg.addr[ADDR_W-1:3];
      fill_l_next = line_now;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fb_addr_reg <= '0;
      fb_eight_reg <= 1'b0;
      hit_reg <= 1'b0;
      hword_reg <= '0;
      fill_v_reg <= 1'b0;
      fill_a_reg <= '0;
      fill_l_reg <= '0;
    end else begin
      fb_addr_reg <= fb_addr_next;
      fb_eight_reg <= fb_eight_next;
      hit_reg <= hit_next;
      hword_reg <= hword_next;
      fill_v_reg <= fill_v_next;
      fill_a_reg <= fill_a_next;
      fill_l_reg <= fill_l_next;
    end
  end

  assign lookup_hit = hit_reg;
  assign lookup_word = hword_reg;
  assign cache_fill_valid = fill_v_reg;
  assign cache_fill_addr = fill_a_reg;
  assign cache_fill_line = fill_l_reg;

  a_attr_held: assert property (@(posedge clk) disable iff (!rst_b)
    fetch_req && !fetch_addr_ack && !fetch_abort |=>
      $stable(fetch_cacheable) && $stable(fetch_user_attr) && $stable(fetch_word_addr))
    else $error("attributes changed under request");

  a_prio_size_held: assert property (@(posedge clk) disable iff (!rst_b)
    fetch_req && !fetch_addr_ack && !fetch_abort |=>
      fetch_req && $stable(fetch_priority) && $stable(fetch_line_size))
    else $error("priority or size changed under request");

  a_prio_source: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(fetch_req) |-> fetch_priority == $past(cfg_reg.ifetch_priority_field))
    else $error("priority not from configuration");

  a_line_size: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(fetch_req) |-> fetch_line_size ==
      ((fetch_cacheable || $past(cfg_reg.noncache_line_size_sel)) ? SIZE_EIGHT : SIZE_FOUR))
    else $error("wrong line size");

  a_abort_drop: assert property (@(posedge clk) disable iff (!rst_b)
    fetch_abort |-> fetch_req ##1 !fetch_req)
    else $error("request not dropped after abort");

  a_ack_drop: assert property (@(posedge clk) disable iff (!rst_b)
    fetch_req && fetch_addr_ack |=> !fetch_req)
    else $error("request not low after ack");

  a_out_limit: assert property (@(posedge clk) disable iff (!rst_b)
    fetch_req |-> out_cnt < MAX_OUT)
    else $error("third outstanding request");

  a_third_gap: assert property (@(posedge clk) disable iff (!rst_b)
    pop && q1_reg.vld |-> !fetch_req ##1 !fetch_req)
    else $error("third request too early");

  a_fill_alloc: assert property (@(posedge clk) disable iff (!rst_b)
    pop |=> cache_fill_valid == ($past(q0_reg.cacheable) &&
      (!$past(cfg_reg.fetch_without_allocate) || $past(q0_reg.touch))))
    else $error("cache fill decision wrong");

endmodule
`default_nettype wire

// ### testbench/fetch_slave_model.sv
// Slave model on the fetch port: acks requests, returns lines in order.
// Shares clk with the master; slow adds ack delay and gaps between beats.
`timescale 1ns/100ps
`default_nettype none
module fetch_slave_model
  import fetch_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wide,
  input wire logic slow,
  input wire logic fetch_req,
  input wire logic [ADDR_W-1:0] fetch_word_addr,
  input wire logic [1:0] fetch_line_size,
  input wire logic fetch_abort,
  output logic fetch_addr_ack,
  output logic slave_width_64,
  output logic fetch_rd_ack,
  output logic [2*WORD_W-1:0] fetch_rd_data,
  output logic [2:0] fetch_rd_word_pos,
  output logic last_beat
);
  typedef struct packed {
    logic [ADDR_W-1:0] base;
    logic [3:0] n;
    logic wd;
  } job_t;
  job_t q[$];
  logic [3:0] beat;
  logic [ADDR_W-1:0] wa;
  logic e8;
  int cnt;
  int gap;
  function automatic logic [WORD_W-1:0] wv(input logic [ADDR_W-1:0] a);
    return {2'h0, a};
  endfunction
  assign slave_width_64 = wide;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_addr_ack <= 1'b0;
      fetch_rd_ack <= 1'b0;
      fetch_rd_data <= '0;
      fetch_rd_word_pos <= 3'h0;
      last_beat <= 1'b0;
      beat <= 4'h0;
      cnt <= 0;
      gap <= 0;
      q.delete();
    end else begin
      fetch_addr_ack <= 1'b0;
      fetch_rd_ack <= 1'b0;
      last_beat <= 1'b0;
      e8 = fetch_line_size == SIZE_EIGHT;
      wa = fetch_word_addr & (e8 ? ~30'h7 : ~30'h3);
      if (fetch_addr_ack) begin
        cnt <= 0;
        if (!fetch_abort) q.push_back('{wa, (e8 ? 4'h8 : 4'h4) >> wide, wide});
      end else if (fetch_req && !fetch_abort && cnt >= (slow ? 2 : 0)) begin
        fetch_addr_ack <= 1'b1;
      end else begin
        cnt <= (fetch_req && !fetch_abort) ? cnt + 1 : 0;
      end
      if (q.size() != 0 && gap == 0) begin
        wa = q[0].base + ADDR_W'(beat << q[0].wd);
        fetch_rd_ack <= 1'b1;
        fetch_rd_word_pos <= wa[2:0];
        fetch_rd_data <= {wv(wa), q[0].wd ? wv(wa + 30'h1) : wv(wa)};
        gap <= slow ? 2 : 0;
        if (beat == q[0].n - 4'h1) begin
          void'(q.pop_front());
          beat <= 4'h0;
          last_beat <= 1'b1;
        end else begin
          beat <= beat + 4'h1;
        end
      end else begin
        // Idle bus inverts the data each cycle, so the last word shows again every second idle cycle
        fetch_rd_data <= ~fetch_rd_data;
        if (gap > 0) gap <= gap - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the fetch bus master.
// Assumes fetch_slave_model on the fetch port; core side driven here.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import fetch_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cfg_wr = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_cancel = 1'b0;
  logic wide = 1'b0;
  logic slow = 1'b0;
  core_cfg_t cfg_in = CFG_RESET;
  fetch_cmd_t cmd = '0;
  logic [ADDR_W-1:0] lookup_addr = '0;
  logic cmd_ready, lookup_hit, cache_fill_valid, fetch_req, fetch_cacheable;
  logic fetch_user_attr, fetch_abort, fetch_addr_ack, slave_width_64, fetch_rd_ack, last_beat;
  logic [WORD_W-1:0] lookup_word;
  logic [ADDR_W-4:0] cache_fill_addr, fill_a;
  logic [LINE_WORDS*WORD_W-1:0] cache_fill_line, fill_l;
  logic [ADDR_W-1:0] fetch_word_addr;
  logic [1:0] fetch_line_size, fetch_priority;
  logic [2*WORD_W-1:0] fetch_rd_data;
  logic [2:0] fetch_rd_word_pos;
  logic [35:0] snap;
  logic prev_req = 1'b0, prev_take = 1'b0, prev_abort = 1'b0, full_done = 1'b0;
  int bad_count = 0, tests_run = 0, beats = 0, fills = 0, outs = 0, since = 9;
  wire [35:0] cur = {fetch_word_addr, fetch_line_size, fetch_cacheable, fetch_user_attr,
    fetch_priority};
  always #12.5 clk = ~clk;
  instruction_fetch_bus_master dut (.clk(clk), .rst_b(rst_b), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .cmd_cancel(cmd_cancel),
    .lookup_addr(lookup_addr), .lookup_hit(lookup_hit), .lookup_word(lookup_word),
    .cache_fill_valid(cache_fill_valid), .cache_fill_addr(cache_fill_addr),
    .cache_fill_line(cache_fill_line), .fetch_req(fetch_req), .fetch_word_addr(fetch_word_addr),
    .fetch_line_size(fetch_line_size), .fetch_cacheable(fetch_cacheable),
    .fetch_user_attr(fetch_user_attr), .fetch_priority(fetch_priority),
    .fetch_abort(fetch_abort), .fetch_addr_ack(fetch_addr_ack), .slave_width_64(slave_width_64),
    .fetch_rd_ack(fetch_rd_ack), .fetch_rd_data(fetch_rd_data),
    .fetch_rd_word_pos(fetch_rd_word_pos));
  fetch_slave_model slave (.clk(clk), .rst_b(rst_b), .wide(wide), .slow(slow),
    .fetch_req(fetch_req), .fetch_word_addr(fetch_word_addr), .fetch_line_size(fetch_line_size),
    .fetch_abort(fetch_abort), .fetch_addr_ack(fetch_addr_ack), .slave_width_64(slave_width_64),
    .fetch_rd_ack(fetch_rd_ack), .fetch_rd_data(fetch_rd_data),
    .fetch_rd_word_pos(fetch_rd_word_pos), .last_beat(last_beat));
  function automatic logic [WORD_W-1:0] wv(input logic [ADDR_W-1:0] a);
    return {2'h0, a};
  endfunction
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Bus watcher: hold times, spacing, outstanding count
  always @(posedge clk) begin
    if (rst_b) begin
      if (fetch_rd_ack) beats <= beats + 1;
      if (cache_fill_valid) begin
        fills <= fills + 1;
        fill_a <= cache_fill_addr;
        fill_l <= cache_fill_line;
      end
      if (fetch_req && !prev_req) begin
        snap <= cur;
        chk("spacing", 64'(0), 64'(outs == 2 || (full_done && since == 0)));
      end else if (fetch_req || prev_take) begin
        chk("held attrs", 64'(snap), 64'(cur));
      end
      if (prev_take || prev_abort) chk("req low", 64'(0), 64'(fetch_req));
      outs <= outs + int'(fetch_req && fetch_addr_ack && !fetch_abort) - int'(last_beat);
      if (last_beat) begin
        full_done <= outs == 2;
        since <= 0;
      end else if (since < 9) since <= since + 1;
      prev_req <= fetch_req;
      prev_take <= fetch_req && fetch_addr_ack;
      prev_abort <= fetch_req && fetch_abort;
    end
  end
  task automatic set_cfg(input logic n, f, input logic [1:0] p);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_in <= '{n, f, p};
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask
  task automatic fetch(input logic [ADDR_W-1:0] a, input logic c, u, t);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{a, c, u, t};
    for (int i = 0; i < 400; i++) begin
      @(negedge clk);
      if (cmd_ready === 1'b1) break;
    end
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask
  task automatic attrs(input logic [ADDR_W-1:0] a, input logic [1:0] sz, input logic c, u,
      input logic [1:0] p);
    @(negedge clk);
    chk("attrs", 64'({a, sz, c, u, p}), 64'(cur));
  endtask
  task automatic settle;
    for (int i = 0; i < 400; i++) begin
      @(negedge clk);
      if (outs == 0 && fetch_req === 1'b0) break;
    end
    repeat (3) @(negedge clk);
  endtask
  task automatic look(input logic [ADDR_W-1:0] a, input logic hit);
    @(posedge clk);
    lookup_addr <= a;
    @(posedge clk);
    @(negedge clk);
    chk("lookup hit", 64'(hit), 64'(lookup_hit));
    if (hit) chk("lookup word", 64'(wv(a)), 64'(lookup_word));
  endtask
  task automatic t_cache(input logic wd, input logic [1:0] p);
    logic [ADDR_W-1:0] a;
    int b0;
    a = wd ? 30'h245 : 30'h103;
    b0 = beats;
    wide <= wd;
    fetch(a, 1'b1, 1'b1, 1'b0);
    attrs(a, SIZE_EIGHT, 1'b1, 1'b1, p);
    settle;
    chk("beats", 64'(wd ? 4 : 8), 64'(beats - b0));
    chk("fill addr", 64'(a[29:3]), 64'(fill_a));
    for (int i = 0; i < 8; i++) begin
      chk("fill word", 64'(wv({a[29:3], 3'(i)})), 64'(fill_l[i*32+:32]));
    end
    look(a + 30'h2, 1'b1);
    $display("test cacheable line done");
  endtask
  task automatic t_noncache;
    logic [ADDR_W-1:0] a;
    int b0;
    int f0;
    for (int k = 0; k < 4; k++) begin
      a = 30'h205 + 30'(k * 8);
      b0 = beats;
      f0 = fills;
      set_cfg(k[1], 1'b0, 2'(k));
      wide <= k[0];
      fetch(a, 1'b0, 1'b0, 1'b0);
      attrs(a, k[1] ? SIZE_EIGHT : SIZE_FOUR, 1'b0, 1'b0, 2'(k));
      settle;
      chk("nc beats", 64'((k[1] ? 8 : 4) >> k[0]), 64'(beats - b0));
      chk("nc fills", 64'(f0), 64'(fills));
      look(a ^ 30'h2, 1'b1);
    end
    $display("test non-cacheable lines done");
  endtask
  task automatic t_alloc;
    int f0;
    set_cfg(1'b0, 1'b1, 2'b11);
    f0 = fills;
    fetch(30'h308, 1'b1, 1'b0, 1'b0);
    settle;
    chk("no allocate", 64'(f0), 64'(fills));
    look(30'h30c, 1'b1);
    look(30'h21f, 1'b0);
    fetch(30'h318, 1'b1, 1'b0, 1'b1);
    settle;
    chk("touch fill", 64'(f0 + 1), 64'(fills));
    chk("touch addr", 64'(27'h63), 64'(fill_a));
    $display("test allocation done");
  endtask
  task automatic t_abort;
    int b0;
    b0 = beats;
    // Slow slave: abort before ack; fast slave: abort lands on the ack cycle
    for (int s = 1; s >= 0; s--) begin
      slow <= s[0];
      fetch(30'h400, 1'b1, 1'b0, 1'b0);
      @(posedge clk);
      cmd_cancel <= 1'b1;
      @(negedge clk);
      chk("abort", 64'({1'b1, ~s[0]}), 64'({fetch_abort, fetch_addr_ack}));
      @(posedge clk);
      cmd_cancel <= 1'b0;
      @(negedge clk);
      chk("req after abort", 64'(0), 64'(fetch_req));
      settle;
    end
    chk("abort beats", 64'(b0), 64'(beats));
    $display("test abort done");
  endtask
  task automatic t_pipe;
    int b0;
    b0 = beats;
    set_cfg(1'b0, 1'b0, 2'b01);
    wide <= 1'b0;
    fetch(30'h500, 1'b1, 1'b0, 1'b0);
    fetch(30'h508, 1'b1, 1'b0, 1'b0);
    fetch(30'h510, 1'b1, 1'b0, 1'b0);
    settle;
    chk("pipe beats", 64'(24), 64'(beats - b0));
    chk("pipe last fill", 64'(27'ha2), 64'(fill_a));
    $display("test pipelined fetches done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("reset prio", 64'(IPP_RESET), 64'(fetch_priority));
    chk("reset idle", 64'(3'b010), 64'({fetch_req, cmd_ready, fetch_abort}));
    $display("test reset done");
    t_cache(1'b0, IPP_RESET);
    set_cfg(1'b0, 1'b0, 2'b10);
    t_cache(1'b1, 2'b10);
    t_noncache;
    t_alloc;
    t_abort;
    t_pipe;
    complete_run;
  end
  initial begin
    repeat (6000) @(posedge clk);
    bad_count++;
    complete_run;
  end
endmodule
`default_nettype wire
